// ---- hb16_pkg.sv ----
// hb16_pkg: constants for the 16-bit non-multiplexed host-bus port
// assumes: imported by hb16_port and hb16_port_tb_top, nothing else
package hb16_pkg;
   // ------------------------------------------------------------
   // configuration field codes
   // ------------------------------------------------------------
   localparam logic [3:0] HB16_GEN_MODE_HB16 = 4'h3;
   localparam logic [3:0] HB16_HB_NONMUX = 4'h1;
   localparam logic [1:0] HB16_LANE_SEL_OFF = 2'h1;
   localparam logic [3:0] HB16_SCH_ALE = 4'h0;
   localparam logic [3:0] HB16_SCH_CS1 = 4'h1;
   localparam logic [3:0] HB16_SCH_CS2 = 4'h2;
   localparam logic [3:0] HB16_SCH_ALE_CS2 = 4'h3;
   localparam logic [3:0] HB16_SCH_CS4 = 4'h5;
   localparam logic [3:0] HB16_SCH_CS3 = 4'h7;
   // ------------------------------------------------------------
   // address reach per scheme, in address pins
   // ------------------------------------------------------------
   localparam int HB16_REACH_BASE = 12;
   localparam int HB16_REACH_CS2 = 11;
   localparam int HB16_REACH_ALE_CS2 = 10;
   localparam int HB16_EXTRA_PINS = 12;
   // ------------------------------------------------------------
   // widths and reset values
   // ------------------------------------------------------------
   localparam int HB16_DATA_W = 16;
   localparam int HB16_SYNC_RST = 0;
   localparam int HB16_FIFO_DEPTH = 2;
   typedef enum {HB16_IDLE, HB16_ADDR, HB16_STROBE, HB16_DONE} hb16_state_e;
endpackage : hb16_pkg

// ---- hb16_port.sv ----
// hb16_port: bus master for a 16-bit host bus, non-multiplexed option
// assumes: requests come from logic on I_CLK; pins go to the pad ring,
// which resolves the data bus from O_DATA_OE
//
// How it works
// [R1] address and data leave on separate dedicated pins
// [R2] address is masked to the reach of the chosen select scheme
// [R3] active only with general mode 0x3 and host-bus mode 0x1
// [R4] one-cycle address-latch pulse marks the address phase
// [R5] separate read and write strobes mark the data phase
// [R6] one to four chip selects, one per external peripheral
// [R7] two byte-lane selects pick lower or upper data byte
// [R8] byte-select field value 0x1 turns the lane selects off
// [R9] select-scheme field picks latch pulse and chip selects
// [R10] scheme 0x0 latch only; 0x3 latch plus two selects
// [R11] scheme 0x1 one select, 0x2 two selects, no latch
// [R12] the peripheral drives ready low to stretch a cycle
// [R13] ready is honoured in every scheme except latch-only 0x0
// [R14] schemes with three or four selects use twelve extra pins
// [R15] while not ready, address, data, selects and strobe stay put
// [R16] address and latch pulse come before any strobe
`timescale 1ns/1ps
module hb16_port import hb16_pkg::*; #(
   parameter int ADDR_W = HB16_REACH_BASE + HB16_EXTRA_PINS
) (
   input wire logic I_CLK, // system clock, 100 MHz
   input wire logic I_SYS_RST, // async reset, high
   input wire logic [3:0] I_GEN_MODE, // general port mode field
   input wire logic [3:0] I_HB_MODE, // host-bus config mode field
   input wire logic [1:0] I_BYTE_SEL, // byte-lane select field
   input wire logic [3:0] I_SEL_SCHEME, // select-scheme field
   input wire logic I_REQ_VALID, // request offered
   input wire logic I_REQ_WRITE, // 1 write, 0 read
   input wire logic [1:0] I_REQ_CS, // target peripheral
   input wire logic [1:0] I_REQ_BE, // byte enables, bit1 upper
   input wire logic [ADDR_W-1:0] I_REQ_ADDR, // word address
   input wire logic [HB16_DATA_W-1:0] I_REQ_WDATA, // write data
   input wire logic I_RDY, // peripheral ready pin
   input wire logic [HB16_DATA_W-1:0] I_DATA_IN, // data pins in
   output logic O_REQ_READY, // buffer has room
   output logic O_RVALID, // read data pulse
   output logic [HB16_DATA_W-1:0] O_RDATA, // read data
   output logic O_BUSY, // bus cycle running
   output logic [ADDR_W-1:0] O_ADDR, // address pins
   output logic [HB16_DATA_W-1:0] O_DATA_OUT, // data pins out
   output logic O_DATA_OE, // data pins driven
   output logic O_ALE, // address-latch pulse
   output logic O_RD, // read strobe
   output logic O_WR, // write strobe
   output logic [3:0] O_CS, // chip selects, high active
   output logic [1:0] O_LANE_SEL // byte-lane selects, high active
);
   localparam int EW = 1 + 2 + 2 + ADDR_W + HB16_DATA_W;

   // ------------------------------------------------------------
   // scheme decode, used by the cycle logic and the checks
   // ------------------------------------------------------------
   function automatic logic sch_legal(input logic [3:0] s);
      return s <= HB16_SCH_ALE_CS2 || s == HB16_SCH_CS4 ||
         s == HB16_SCH_CS3;
   endfunction : sch_legal

   function automatic logic sch_ale(input logic [3:0] s);
      return s == HB16_SCH_ALE || s == HB16_SCH_ALE_CS2; // R10 R11
   endfunction : sch_ale

   function automatic logic [3:0] sch_cs_mask(input logic [3:0] s);
      unique case (s) // R9
         HB16_SCH_CS1: return 4'h1; // R11
         HB16_SCH_CS2, HB16_SCH_ALE_CS2: return 4'h3; // R10
         HB16_SCH_CS3: return 4'h7; // R14
         HB16_SCH_CS4: return 4'hF; // R14
         default: return 4'h0; // R10
      endcase
   endfunction : sch_cs_mask

   function automatic logic [ADDR_W-1:0] sch_reach(input logic [3:0] s);
      logic [ADDR_W-1:0] ones;
      ones = '1;
      unique case (s) // R2
         HB16_SCH_CS2: return ones >> (ADDR_W - HB16_REACH_CS2);
         HB16_SCH_ALE_CS2: return ones >> (ADDR_W - HB16_REACH_ALE_CS2);
         HB16_SCH_CS3, HB16_SCH_CS4: return ones; // R14
         default: return ones >> (ADDR_W - HB16_REACH_BASE);
      endcase
   endfunction : sch_reach

   logic active;
   assign active = I_GEN_MODE == HB16_GEN_MODE_HB16 && // R3
      I_HB_MODE == HB16_HB_NONMUX && sch_legal(I_SEL_SCHEME);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic rdy_m_reg, rdy_s_reg;
   logic [HB16_DATA_W-1:0] din_m_reg, din_s_reg;

   // ready and data share the same latency, so they stay aligned
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rdy_m_reg <= 1'b0;
         rdy_s_reg <= 1'b0;
         din_m_reg <= '0;
         din_s_reg <= '0;
      end else begin
         rdy_m_reg <= I_RDY; // R12
         rdy_s_reg <= rdy_m_reg;
         din_m_reg <= I_DATA_IN;
         din_s_reg <= din_m_reg;
      end
   end

   // ------------------------------------------------------------
   // two-entry request buffer
   // ------------------------------------------------------------
   logic [EW-1:0] fifo_mem [HB16_FIFO_DEPTH];
   logic wr_ptr_reg, rd_ptr_reg;
   logic [1:0] cnt_reg, cnt_next;
   logic req_rdy_reg;
   logic push, pop;
   hb16_state_e state_reg;
   logic [EW-1:0] head;

   assign push = I_REQ_VALID && req_rdy_reg;
   assign pop = state_reg == HB16_IDLE && cnt_reg != 2'h0 && active;
   assign head = fifo_mem[rd_ptr_reg];
   assign cnt_next = cnt_reg + 2'(push) - 2'(pop);

   // storage holds no control state, so it needs no reset
   always_ff @(posedge I_CLK) begin
      if (push) begin
         fifo_mem[wr_ptr_reg] <= {I_REQ_WRITE, I_REQ_CS, I_REQ_BE,
            I_REQ_ADDR, I_REQ_WDATA};
      end
   end

   // pointers, fill count and registered room flag
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         req_rdy_reg <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg ^ push;
         rd_ptr_reg <= rd_ptr_reg ^ pop;
         cnt_reg <= cnt_next;
         req_rdy_reg <= active && cnt_next != 2'h2; // R3
      end
   end

   // ------------------------------------------------------------
   // bus cycle sequencer
   // ------------------------------------------------------------
   logic h_we;
   logic [1:0] h_cs, h_be;
   logic [ADDR_W-1:0] h_addr;
   logic [HB16_DATA_W-1:0] h_wd;
   assign {h_we, h_cs, h_be, h_addr, h_wd} = head;

   logic we_reg, use_rdy_reg, lane_en_reg, strobe_seen_reg;
   logic [ADDR_W-1:0] mask_reg;
   logic strobe_end;
   // the strobe never ends on its first edge: ready and data seen there
   // left the pins before the selects did, so they would be stale
   assign strobe_end = strobe_seen_reg && // R15
      (!use_rdy_reg || rdy_s_reg); // R13

   // marks every strobe edge after the first
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         strobe_seen_reg <= 1'b0;
      end else begin
         strobe_seen_reg <= state_reg == HB16_STROBE;
      end
   end

   // one cycle of address, strobe until ready, one cycle of hold
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state_reg <= HB16_IDLE;
      end else begin
         unique case (state_reg)
            HB16_IDLE: if (pop) state_reg <= HB16_ADDR;
            HB16_ADDR: state_reg <= HB16_STROBE; // R16
            HB16_STROBE: if (strobe_end) state_reg <= HB16_DONE;
            HB16_DONE: state_reg <= HB16_IDLE;
         endcase
      end
   end

   // per-cycle settings, frozen at the start of each cycle
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         we_reg <= 1'b0;
         use_rdy_reg <= 1'b0;
         lane_en_reg <= 1'b0;
         mask_reg <= '0;
      end else if (pop) begin
         we_reg <= h_we;
         use_rdy_reg <= I_SEL_SCHEME != HB16_SCH_ALE; // R13
         lane_en_reg <= I_BYTE_SEL != HB16_LANE_SEL_OFF; // R8
         mask_reg <= sch_reach(I_SEL_SCHEME); // R2
      end
   end

   // address, data, selects: loaded once, held through the wait
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_ADDR <= '0;
         O_DATA_OUT <= '0;
         O_DATA_OE <= 1'b0;
         O_CS <= 4'h0;
         O_LANE_SEL <= 2'h0;
      end else if (pop) begin
         O_ADDR <= h_addr & sch_reach(I_SEL_SCHEME); // R1 R2
         O_DATA_OUT <= h_wd; // R1
         O_DATA_OE <= h_we;
         O_CS <= (4'h1 << h_cs) & sch_cs_mask(I_SEL_SCHEME); // R6 R9
         O_LANE_SEL <= I_BYTE_SEL != HB16_LANE_SEL_OFF ? h_be : 2'h0; // R7 R8
      end else if (state_reg == HB16_DONE) begin
         O_DATA_OE <= 1'b0;
         O_CS <= 4'h0;
         O_LANE_SEL <= 2'h0;
      end
   end

   // latch pulse and strobes
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_ALE <= 1'b0;
         O_RD <= 1'b0;
         O_WR <= 1'b0;
      end else begin
         O_ALE <= pop && sch_ale(I_SEL_SCHEME); // R4 R10 R11
         if (state_reg == HB16_ADDR) begin
            O_RD <= !we_reg; // R5 R16
            O_WR <= we_reg; // R5 R16
         end else if (state_reg == HB16_STROBE && strobe_end) begin
            O_RD <= 1'b0; // R15
            O_WR <= 1'b0;
         end
      end
   end

   // read data taken one edge after the strobe ends: the synced pins
   // then show what the peripheral drove while the strobe stood
   always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_RDATA <= '0;
         O_RVALID <= 1'b0;
         O_BUSY <= 1'b0;
      end else begin
         O_RVALID <= state_reg == HB16_DONE && !we_reg;
         if (state_reg == HB16_DONE && !we_reg) begin
            O_RDATA <= din_s_reg;
         end
         O_BUSY <= pop || (state_reg != HB16_IDLE &&
            state_reg != HB16_DONE);
      end
   end

   assign O_REQ_READY = req_rdy_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);

   a_ale_one_cycle: assert property (O_ALE |=> !O_ALE) // R4
      else $error("latch pulse longer than one cycle");
   a_ale_then_strobe: assert property ( // R16
      O_ALE |=> (O_RD || O_WR) && $stable(O_ADDR))
      else $error("strobe does not follow latch pulse");
   a_ale_scheme: assert property ( // R10
      O_ALE |-> $past(sch_ale(I_SEL_SCHEME)))
      else $error("latch pulse in a scheme without latch");
   a_wait_hold: assert property ( // R15
      state_reg == HB16_STROBE && !strobe_end |=>
      $stable(O_ADDR) && $stable(O_CS) && $stable(O_DATA_OUT) &&
      (O_RD || O_WR))
      else $error("bus changed while peripheral not ready");
   a_strobe_excl: assert property (!(O_RD && O_WR)) // R5
      else $error("read and write strobes together");
   a_cs_onehot: assert property ($onehot0(O_CS)) // R6
      else $error("more than one chip select");
   a_lane_off: assert property ( // R8
      (O_RD || O_WR) && !lane_en_reg |-> O_LANE_SEL == 2'h0)
      else $error("byte selects driven while disabled");
   a_oe_write: assert property ( // R1
      O_WR |-> O_DATA_OE && !O_RD)
      else $error("write strobe without driven data");
   a_addr_reach: assert property ( // R2
      (O_RD || O_WR) |-> (O_ADDR & ~mask_reg) == '0)
      else $error("address beyond scheme reach");
   a_ready_mode: assert property ( // R3
      O_REQ_READY |-> $past(active))
      else $error("request taken outside host-bus mode");
   a_no_wait_len: assert property ( // R13
      $rose(O_RD || O_WR) && !use_rdy_reg |=>
      (O_RD || O_WR) ##1 !(O_RD || O_WR))
      else $error("strobe length wrong without ready");
   a_strobe_min: assert property ( // R15
      $rose(O_RD || O_WR) |=> O_RD || O_WR)
      else $error("strobe shorter than two cycles");

   c_write: cover property ($rose(O_WR));
   c_read: cover property (O_RVALID);
   c_wait: cover property ((O_RD && use_rdy_reg && !rdy_s_reg) [*3]);
   c_full: cover property (cnt_reg == 2'h2);
endmodule : hb16_port

// ---- hb16_periph.sv ----
// hb16_periph: behavioural peripheral behind the host-bus pins
// assumes: sees the pins of hb16_port; wait count comes from the bench
`timescale 1ns/1ps
module hb16_periph (
   input wire logic i_clk, // system clock
   input wire logic [23:0] i_addr, // address pins
   input wire logic [15:0] i_data, // data pins from port
   input wire logic i_rd, // read strobe
   input wire logic i_wr, // write strobe
   input wire logic i_sel, // latch pulse or any chip select
   input wire logic [1:0] i_lanes, // byte lanes, 11 when off
   input wire logic [3:0] i_waits, // wait cycles to insert
   output logic o_rdy, // ready back to port
   output logic [15:0] o_data // data pins to port
);
   logic [15:0] mem [16];
   logic [3:0] cnt = 4'h0;
   logic [15:0] last = 16'h0000;
   // ------------------------------------------------------------
   // cycle age and storage
   // ------------------------------------------------------------
   // wait asked from the address phase, as sync delay hides late asks
   always @(posedge i_clk) begin
      cnt <= (i_sel || i_rd || i_wr) ? cnt + 4'h1 : 4'h0;
      if (i_wr) begin
         if (i_lanes[0]) mem[i_addr[3:0]][7:0] <= i_data[7:0];
         if (i_lanes[1]) mem[i_addr[3:0]][15:8] <= i_data[15:8];
      end
      if (i_sel || i_rd) last <= o_data;
   end
   assign o_rdy = !((i_sel || i_rd || i_wr) && cnt < i_waits);
   // released bus shows the inverse, so a stale sample cannot pass
   assign o_data = (i_sel || i_rd) ? mem[i_addr[3:0]] : ~last;
endmodule : hb16_periph

// ---- hb16_port_tb_top.sv ----
// hb16_port_tb_top: self-checking bench for hb16_port
// assumes: hb16_periph answers on the pins; one 100 MHz clock
`timescale 1ns/1ps
module hb16_port_tb_top import hb16_pkg::*;;
   logic I_CLK = 0, I_SYS_RST = 1, I_REQ_VALID = 0, I_REQ_WRITE = 0;
   logic [3:0] I_GEN_MODE = 4'h3, I_HB_MODE = 4'h1, I_SEL_SCHEME = 4'h0;
   logic [1:0] I_BYTE_SEL = 2'h0, I_REQ_CS = 2'h0, I_REQ_BE = 2'h3;
   logic [23:0] I_REQ_ADDR = 24'h0, O_ADDR, s_addr;
   logic [15:0] I_REQ_WDATA = 16'h0, I_DATA_IN, O_RDATA, O_DATA_OUT;
   logic I_RDY, O_REQ_READY, O_RVALID, O_BUSY, O_DATA_OE, O_ALE, O_RD, O_WR;
   logic [3:0] O_CS, s_cs, waits = 4'h0;
   logic [1:0] O_LANE_SEL, s_lane;
   logic hold_err;
   int fail_count = 0, checks_done = 0, slen, ale_n, s_ale, takes;
   logic [3:0] schs [6] = '{HB16_SCH_ALE, HB16_SCH_CS1, HB16_SCH_CS2,
      HB16_SCH_ALE_CS2, HB16_SCH_CS4, HB16_SCH_CS3};
   always #5 I_CLK = ~I_CLK;
   hb16_port dut (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
      .I_GEN_MODE(I_GEN_MODE), .I_HB_MODE(I_HB_MODE),
      .I_BYTE_SEL(I_BYTE_SEL), .I_SEL_SCHEME(I_SEL_SCHEME),
      .I_REQ_VALID(I_REQ_VALID), .I_REQ_WRITE(I_REQ_WRITE),
      .I_REQ_CS(I_REQ_CS), .I_REQ_BE(I_REQ_BE), .I_REQ_ADDR(I_REQ_ADDR),
      .I_REQ_WDATA(I_REQ_WDATA), .I_RDY(I_RDY), .I_DATA_IN(I_DATA_IN),
      .O_REQ_READY(O_REQ_READY), .O_RVALID(O_RVALID), .O_RDATA(O_RDATA),
      .O_BUSY(O_BUSY), .O_ADDR(O_ADDR), .O_DATA_OUT(O_DATA_OUT),
      .O_DATA_OE(O_DATA_OE), .O_ALE(O_ALE), .O_RD(O_RD), .O_WR(O_WR),
      .O_CS(O_CS), .O_LANE_SEL(O_LANE_SEL));
   hb16_periph peer (.i_clk(I_CLK), .i_addr(O_ADDR), .i_data(O_DATA_OUT),
      .i_rd(O_RD), .i_wr(O_WR), .i_sel(O_ALE || (|O_CS)),
      .i_lanes(I_BYTE_SEL == HB16_LANE_SEL_OFF ? 2'h3 : O_LANE_SEL),
      .i_waits(waits), .o_rdy(I_RDY), .o_data(I_DATA_IN));
   // ------------------------------------------------------------
   // pin monitor: strobe length, held values, latch pulses
   // ------------------------------------------------------------
   always @(posedge I_CLK) begin
      if (O_ALE === 1'b1) ale_n <= ale_n + 1;
      if (O_RD === 1'b1 || O_WR === 1'b1) begin
         slen <= slen + 1;
         if (slen == 0) begin
            s_addr <= O_ADDR;
            s_cs <= O_CS;
            s_lane <= O_LANE_SEL;
            s_ale <= ale_n;
         end else if (O_ADDR !== s_addr || O_CS !== s_cs) hold_err <= 1;
      end
   end
   task final_report;
      $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   task check(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s exp=%h seen=%h", nm, exp, seen);
      end
   endtask : check
   task tick_bounded(inout int n);
      @(posedge I_CLK);
      n++;
      if (n > 2000) begin
         fail_count++;
         final_report();
      end
   endtask : tick_bounded
   function automatic int reach(input logic [3:0] s);
      case (s)
         HB16_SCH_CS2: return HB16_REACH_CS2;
         HB16_SCH_ALE_CS2: return HB16_REACH_ALE_CS2;
         HB16_SCH_CS4, HB16_SCH_CS3: return 24;
         default: return HB16_REACH_BASE;
      endcase
   endfunction : reach
   function automatic int ncs(input logic [3:0] s);
      case (s)
         HB16_SCH_ALE: return 0;
         HB16_SCH_CS1: return 1;
         HB16_SCH_CS4: return 4;
         HB16_SCH_CS3: return 3;
         default: return 2;
      endcase
   endfunction : ncs
   // one request, then wait for its bus cycle to finish and judge the pins
   task automatic op(input logic w, input logic [1:0] cs, be,
      input logic [23:0] a, input logic [15:0] d);
      int n;
      logic [3:0] s;
      logic ale;
      n = 0;
      // the caller's scheme change lands on the edge it was made at
      @(negedge I_CLK);
      s = I_SEL_SCHEME;
      ale = (s == HB16_SCH_ALE || s == HB16_SCH_ALE_CS2);
      slen = 0;
      ale_n = 0;
      hold_err = 0;
      @(posedge I_CLK);
      I_REQ_VALID <= 1;
      I_REQ_WRITE <= w;
      I_REQ_CS <= cs;
      I_REQ_BE <= be;
      I_REQ_ADDR <= a;
      I_REQ_WDATA <= d;
      do tick_bounded(n); while (O_REQ_READY !== 1'b1);
      I_REQ_VALID <= 0;
      if (w) do tick_bounded(n); while (slen == 0 || O_BUSY !== 1'b0);
      else do tick_bounded(n); while (O_RVALID !== 1'b1);
      if (!w) check("rdata", O_RDATA, d);
      check("addr", s_addr, a & 24'((25'h1 << reach(s)) - 1));
      check("cs", s_cs, cs < ncs(s) ? 4'h1 << cs : 4'h0);
      check("lane_sel", s_lane, I_BYTE_SEL == HB16_LANE_SEL_OFF ? 2'h0 : be);
      check("ale", s_ale, ale);
      check("hold", hold_err, 0);
      // two-cycle minimum strobe; only a selected peripheral can stretch
      if (s == HB16_SCH_ALE) check("len0", slen, 2);
      else check("stretch", slen, (s_cs != 0 || ale) ? waits + 2 : 2);
   endtask : op
   initial begin
      logic [23:0] a;
      logic [15:0] d;
      int n;
      void'($urandom(32'h6fab2e43));
      repeat (6) @(posedge I_CLK);
      I_SYS_RST <= 0;
      // every scheme, lane selects on and off, random waits
      foreach (schs[i]) for (int b = 0; b < 2; b++) begin
         I_SEL_SCHEME <= schs[i];
         I_BYTE_SEL <= b[1:0];
         waits <= 4'($urandom_range(0, 3));
         a = 24'($urandom);
         d = 16'($urandom);
         op(1, 2'($urandom), 2'h3, a, d);
         op(0, 2'($urandom), 2'h3, a, d);
      end
      // upper-lane write must leave the lower byte alone
      I_SEL_SCHEME <= HB16_SCH_CS1;
      I_BYTE_SEL <= 2'h0;
      op(1, 2'h0, 2'h3, 24'h5, 16'hAAAA);
      op(1, 2'h0, 2'h2, 24'h5, 16'h55FF);
      op(0, 2'h0, 2'h3, 24'h5, 16'h55AA);
      // long waits: the two-entry buffer fills and must refuse
      waits <= 4'h8;
      takes = 0;
      @(posedge I_CLK);
      I_REQ_VALID <= 1;
      I_REQ_WRITE <= 1;
      repeat (12) begin
         @(posedge I_CLK);
         if (O_REQ_READY === 1'b1) takes++;
      end
      I_REQ_VALID <= 0;
      check("fill", takes, 3);
      n = 0;
      do tick_bounded(n); while (O_BUSY !== 1'b0 || O_REQ_READY !== 1'b1);
      // wrong mode codes close the request side
      I_GEN_MODE <= 4'h0;
      repeat (3) @(posedge I_CLK);
      check("gen_off", O_REQ_READY, 0);
      I_GEN_MODE <= HB16_GEN_MODE_HB16;
      I_HB_MODE <= 4'h0;
      repeat (3) @(posedge I_CLK);
      check("hb_off", O_REQ_READY, 0);
      final_report();
   end
endmodule : hb16_port_tb_top
